/* logic/lper_defines.vh */
/*
 Constants for the link parity and error reporting block: register offsets,
 field positions, codes and reset values. Assumes inclusion by bare name.
*/
`ifndef LPER_DEFINES_VH
`define LPER_DEFINES_VH

// Register byte offsets on the AXI4-Lite slave
`define LPER_OFF_ERR 8'h00
`define LPER_OFF_MASK 8'h04
`define LPER_OFF_CTRL 8'h08
`define LPER_OFF_CFGHDR 8'h0c
`define LPER_OFF_CFGSTAT 8'h10
`define LPER_OFF_CNT 8'h14

// Error register fields
`define LPER_CODE_LO 0
`define LPER_CODE_HI 1
`define LPER_SRC_LO 10
`define LPER_SRC_HI 15
`define LPER_BIT_HDRERR 2
`define LPER_BIT_RXPE 24
`define LPER_BIT_RXSUM 25
`define LPER_BIT_TXPE 27
`define LPER_BIT_TXSUM 28

// Condition codes
`define LPER_CC_HEADER 2'h0
`define LPER_CC_DATA 2'h1

// Control register fields
`define LPER_CTRL_VHUB 0
`define LPER_CTRL_RESET 32'h0000_0000

// Fixed configuration values
`define LPER_HDR_TYPE 8'h00
`define LPER_INT_PIN 8'h01
`define LPER_CFG_STATUS 16'h0400

// Error notification packet marker on the transmit side
`define LPER_ERRPKT_BYTE 8'he5

`endif

/* logic/lper_parity.v */
/*
 Byte parity generator and checker used on both link paths.
 Assumes byte-wide data with one odd-parity bit per byte.
*/
`timescale 1ns/100ps
module lper_parity (
	input wire [7:0] data,
	input wire par_in,
	output wire par_out,
	output wire par_bad
);
	// Odd parity: the check bit makes the total count of ones odd
	assign par_out = ~(^data);
	// An even count of ones over byte and check bit is a fault
	assign par_bad = ~(^{data, par_in});
endmodule // lper_parity

/* logic/lper_axil.v */
/*
 AXI4-Lite register slave front end: takes one write and one read at a time
 and presents a single-cycle strobe to the register file.
 Assumes the register file answers reads combinationally from its flops.
*/
`timescale 1ns/100ps
module lper_axil (
	input wire aclk,
	input wire aresetn,
	input wire [7:0] s_axi_awaddr,
	input wire s_axi_awvalid,
	output reg s_axi_awready,
	input wire [31:0] s_axi_wdata,
	input wire [3:0] s_axi_wstrb,
	input wire s_axi_wvalid,
	output reg s_axi_wready,
	output reg [1:0] s_axi_bresp,
	output reg s_axi_bvalid,
	input wire s_axi_bready,
	input wire [7:0] s_axi_araddr,
	input wire s_axi_arvalid,
	output reg s_axi_arready,
	output reg [31:0] s_axi_rdata,
	output reg [1:0] s_axi_rresp,
	output reg s_axi_rvalid,
	input wire s_axi_rready,
	output reg wr_stb,
	output reg [7:0] wr_addr,
	output reg [31:0] wr_data,
	output reg [3:0] wr_strb,
	input wire wr_err,
	output wire [7:0] rd_addr,
	output wire rd_stb,
	input wire [31:0] rd_data,
	input wire rd_err
);
	reg aw_have_q;
	reg w_have_q;
	reg [7:0] ar_addr_q;
	reg ar_have_q;

	assign rd_addr = ar_addr_q;
	assign rd_stb = ar_have_q & ~s_axi_rvalid;

	// Write side: address and data caught in either order, one answer
	always @(posedge aclk) begin
		wr_stb <= 1'b0;
		if (!aresetn) begin
			s_axi_awready <= 1'b1;
			s_axi_wready <= 1'b1;
			aw_have_q <= 1'b0;
			w_have_q <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= 2'h0;
			wr_addr <= 8'h00;
			wr_data <= 32'h0000_0000;
			wr_strb <= 4'h0;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				wr_addr <= s_axi_awaddr;
				aw_have_q <= 1'b1;
				s_axi_awready <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				wr_data <= s_axi_wdata;
				wr_strb <= s_axi_wstrb;
				w_have_q <= 1'b1;
				s_axi_wready <= 1'b0;
			end
			if (aw_have_q && w_have_q && !s_axi_bvalid) begin
				wr_stb <= 1'b1;
				aw_have_q <= 1'b0;
				w_have_q <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= wr_err ? 2'h2 : 2'h0;
			end
			if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
				s_axi_awready <= 1'b1;
				s_axi_wready <= 1'b1;
			end
		end
	end

	// Read side: one outstanding read, data captured from the register file
	always @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b1;
			ar_have_q <= 1'b0;
			ar_addr_q <= 8'h00;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= 2'h0;
		end else begin
			if (s_axi_arvalid && s_axi_arready) begin
				ar_addr_q <= s_axi_araddr;
				ar_have_q <= 1'b1;
				s_axi_arready <= 1'b0;
			end
			if (rd_stb) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rdata <= rd_data;
				s_axi_rresp <= rd_err ? 2'h2 : 2'h0;
				ar_have_q <= 1'b0;
			end
			if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
				s_axi_arready <= 1'b1;
			end
		end
	end
endmodule // lper_axil

/* logic/lper_link_err.v */
/*
 Link parity generation, parity checking and error reporting for one
 cluster interconnect adapter, with an AXI4-Lite register file.
 Assumes a byte stream on each link path framed by start and end strobes,
 one odd-parity bit per byte, and a linecard or peer that raises its own
 error indication toward this adapter.
*/
// The AXI4-Lite interface to the registers and the register offsets were left to the implementer.
`timescale 1ns/100ps
`include "lper_defines.vh"

module lper_link_err (
	input wire aclk,
	input wire aresetn,
	input wire [7:0] s_axi_awaddr,
	input wire s_axi_awvalid,
	output wire s_axi_awready,
	input wire [31:0] s_axi_wdata,
	input wire [3:0] s_axi_wstrb,
	input wire s_axi_wvalid,
	output wire s_axi_wready,
	output wire [1:0] s_axi_bresp,
	output wire s_axi_bvalid,
	input wire s_axi_bready,
	input wire [7:0] s_axi_araddr,
	input wire s_axi_arvalid,
	output wire s_axi_arready,
	output wire [31:0] s_axi_rdata,
	output wire [1:0] s_axi_rresp,
	output wire s_axi_rvalid,
	input wire s_axi_rready,
	input wire tx_valid,
	input wire tx_sop,
	input wire tx_eop,
	input wire [7:0] tx_data,
	input wire tx_bcast,
	output reg tx_ready,
	output reg link_tx_valid,
	output reg link_tx_sop,
	output reg link_tx_eop,
	output reg [7:0] link_tx_data,
	output reg link_tx_par,
	input wire link_rx_valid,
	input wire link_rx_sop,
	input wire link_rx_eop,
	input wire [7:0] link_rx_data,
	input wire link_rx_par,
	input wire link_err_notify,
	output reg rx_valid,
	output reg rx_sop,
	output reg rx_eop,
	output reg [7:0] rx_data,
	output reg rx_abort,
	output reg rx_bad,
	output reg irq
);
	// Receive framing states
	localparam RX_IDLE = 2'h0;
	localparam RX_HDR = 2'h1;
	localparam RX_DATA = 2'h2;
	localparam RX_DROP = 2'h3;

	wire wr_stb;
	wire [7:0] wr_addr;
	wire [31:0] wr_data;
	wire [3:0] wr_strb;
	wire [7:0] rd_addr;
	wire rd_stb;
	reg [31:0] rd_data;
	reg rd_err;
	reg wr_err;

	reg [1:0] rx_state_q;
	reg rx_data_bad_q;
	reg [5:0] rx_src_q;
	reg [1:0] code_q;
	reg [5:0] src_q;
	reg hdr_err_q;
	reg rxpe_q;
	reg rxsum_q;
	reg txpe_q;
	reg txsum_q;
	reg [31:0] mask_q;
	reg [31:0] ctrl_q;
	reg [15:0] err_cnt_q;
	reg errpkt_pend_q;
	reg [1:0] loop_q;
	wire tx_par;
	wire rx_par_bad;
	reg rx_hdr_fail;
	reg rx_data_fail;
	wire [31:0] err_word;
	wire [31:0] clr;

	lper_axil u_axil (
		.aclk(aclk),
		.aresetn(aresetn),
		.s_axi_awaddr(s_axi_awaddr),
		.s_axi_awvalid(s_axi_awvalid),
		.s_axi_awready(s_axi_awready),
		.s_axi_wdata(s_axi_wdata),
		.s_axi_wstrb(s_axi_wstrb),
		.s_axi_wvalid(s_axi_wvalid),
		.s_axi_wready(s_axi_wready),
		.s_axi_bresp(s_axi_bresp),
		.s_axi_bvalid(s_axi_bvalid),
		.s_axi_bready(s_axi_bready),
		.s_axi_araddr(s_axi_araddr),
		.s_axi_arvalid(s_axi_arvalid),
		.s_axi_arready(s_axi_arready),
		.s_axi_rdata(s_axi_rdata),
		.s_axi_rresp(s_axi_rresp),
		.s_axi_rvalid(s_axi_rvalid),
		.s_axi_rready(s_axi_rready),
		.wr_stb(wr_stb),
		.wr_addr(wr_addr),
		.wr_data(wr_data),
		.wr_strb(wr_strb),
		.wr_err(wr_err),
		.rd_addr(rd_addr),
		.rd_stb(rd_stb),
		.rd_data(rd_data),
		.rd_err(rd_err)
	);

	// Parity for the outgoing byte, and check of the incoming one
	lper_parity u_tx_par (
		.data(tx_data),
		.par_in(1'b0),
		.par_out(tx_par),
		.par_bad()
	);

	lper_parity u_rx_par (
		.data(link_rx_data),
		.par_in(link_rx_par),
		.par_out(),
		.par_bad(rx_par_bad)
	);

	// Transmit path: every byte leaves with its check bit; a pending error
	// report packet in hubless mode takes the link at the next byte slot, even inside a user packet
	always @(posedge aclk) begin
		if (!aresetn) begin
			link_tx_valid <= 1'b0;
			link_tx_sop <= 1'b0;
			link_tx_eop <= 1'b0;
			link_tx_data <= 8'h00;
			link_tx_par <= 1'b0;
			tx_ready <= 1'b0;
			loop_q <= 2'h0;
		end else begin
			tx_ready <= ~(errpkt_pend_q & ctrl_q[`LPER_CTRL_VHUB]);
			link_tx_valid <= 1'b0;
			link_tx_sop <= 1'b0;
			link_tx_eop <= 1'b0;
			if (errpkt_pend_q && ctrl_q[`LPER_CTRL_VHUB] && !tx_ready) begin
				link_tx_valid <= 1'b1;
				link_tx_sop <= 1'b1;
				link_tx_eop <= 1'b1;
				link_tx_data <= `LPER_ERRPKT_BYTE;
				link_tx_par <= ~(^`LPER_ERRPKT_BYTE);
			end else if (tx_valid && tx_ready) begin
				link_tx_valid <= 1'b1;
				link_tx_sop <= tx_sop;
				link_tx_eop <= tx_eop;
				link_tx_data <= tx_data;
				link_tx_par <= tx_par;
			end
			// Broadcast: the flag of each packet start is shifted into loop_q, which nothing reads
			if (tx_valid && tx_ready && tx_sop) begin
				loop_q <= {loop_q[0], tx_bcast};
			end
		end
	end

	// Combinational parity verdicts for the current received byte
	always @* begin
		rx_hdr_fail = 1'b0;
		rx_data_fail = 1'b0;
		if (link_rx_valid && link_rx_sop && rx_par_bad) begin
			rx_hdr_fail = 1'b1;
		end
		if (link_rx_valid && link_rx_eop && !link_rx_sop && rx_state_q == RX_DATA) begin
			rx_data_fail = rx_data_bad_q | rx_par_bad;
		end
	end

	// Receive framing: header is first byte, data parity summed to the end
	always @(posedge aclk) begin
		if (!aresetn) begin
			rx_state_q <= RX_IDLE;
			rx_data_bad_q <= 1'b0;
			rx_src_q <= 6'h00;
			rx_valid <= 1'b0;
			rx_sop <= 1'b0;
			rx_eop <= 1'b0;
			rx_data <= 8'h00;
			rx_abort <= 1'b0;
			rx_bad <= 1'b0;
		end else begin
			rx_valid <= 1'b0;
			rx_sop <= 1'b0;
			rx_eop <= 1'b0;
			rx_abort <= 1'b0;
			rx_bad <= 1'b0;
			case (rx_state_q)
			RX_IDLE, RX_HDR, RX_DATA, RX_DROP: begin
				if (link_rx_valid && link_rx_sop) begin
					rx_src_q <= link_rx_data[5:0];
					rx_data_bad_q <= 1'b0;
					if (rx_hdr_fail) begin
						rx_state_q <= link_rx_eop ? RX_IDLE : RX_DROP;
						rx_abort <= 1'b1;
					end else begin
						rx_state_q <= link_rx_eop ? RX_IDLE : RX_DATA;
						rx_valid <= 1'b1;
						rx_sop <= 1'b1;
						rx_eop <= link_rx_eop;
						rx_data <= link_rx_data;
					end
				end else if (link_rx_valid && rx_state_q == RX_DATA) begin
					rx_data_bad_q <= rx_data_bad_q | rx_par_bad;
					rx_valid <= 1'b1;
					rx_eop <= link_rx_eop;
					rx_bad <= rx_data_fail;
					rx_data <= link_rx_data;
					if (link_rx_eop) begin
						rx_state_q <= RX_IDLE;
					end
				end else if (link_rx_valid && link_rx_eop) begin
					rx_state_q <= RX_IDLE;
				end
			end
			default: begin
				rx_state_q <= RX_IDLE;
			end
			endcase
		end
	end

	// Write-one-to-clear mask for the error register
	assign clr = (wr_stb && wr_addr == `LPER_OFF_ERR) ? wr_data : 32'h0000_0000;

	// Sticky error state; a new event in the clearing cycle wins. Port
	// online state lives elsewhere and is never touched from here.
	always @(posedge aclk) begin
		if (!aresetn) begin
			rxpe_q <= 1'b0;
			rxsum_q <= 1'b0;
			txpe_q <= 1'b0;
			txsum_q <= 1'b0;
			hdr_err_q <= 1'b0;
			code_q <= 2'h0;
			src_q <= 6'h00;
			errpkt_pend_q <= 1'b0;
			err_cnt_q <= 16'h0000;
		end else begin
			if (clr[`LPER_BIT_RXPE]) rxpe_q <= 1'b0;
			if (clr[`LPER_BIT_RXSUM]) rxsum_q <= 1'b0;
			if (clr[`LPER_BIT_TXPE]) txpe_q <= 1'b0;
			if (clr[`LPER_BIT_TXSUM]) txsum_q <= 1'b0;
			if (clr[`LPER_BIT_HDRERR]) hdr_err_q <= 1'b0;
			if (clr[`LPER_BIT_RXPE]) begin
				code_q <= 2'h0;
				src_q <= 6'h00;
			end
			if (rx_data_fail) begin
				rxpe_q <= 1'b1;
				rxsum_q <= 1'b1;
				code_q <= `LPER_CC_DATA;
				src_q <= rx_src_q;
				errpkt_pend_q <= 1'b1;
				err_cnt_q <= err_cnt_q + 16'h0001;
			end else if (rx_hdr_fail) begin
				rxpe_q <= 1'b1;
				rxsum_q <= 1'b1;
				hdr_err_q <= 1'b1;
				code_q <= `LPER_CC_HEADER;
				src_q <= link_rx_data[5:0];
				errpkt_pend_q <= 1'b1;
				err_cnt_q <= err_cnt_q + 16'h0001;
			end else if (ctrl_q[`LPER_CTRL_VHUB] && !tx_ready) begin
				// Report leaves this cycle; clearing here keeps it to one copy
				errpkt_pend_q <= 1'b0;
			end else if (!ctrl_q[`LPER_CTRL_VHUB]) begin
				errpkt_pend_q <= 1'b0; // Only the peer in hubless mode hears it
			end
			if (link_err_notify) begin
				txpe_q <= 1'b1;
				txsum_q <= 1'b1;
				err_cnt_q <= err_cnt_q + 16'h0001;
			end
		end
	end

	assign err_word = {3'h0, txsum_q, txpe_q, 1'b0, rxsum_q, rxpe_q, 8'h00,
		src_q, 7'h00, hdr_err_q, code_q};

	// Mask, control, and the level interrupt from a flop
	always @(posedge aclk) begin
		if (!aresetn) begin
			mask_q <= 32'h0000_0000;
			ctrl_q <= `LPER_CTRL_RESET;
			irq <= 1'b0;
		end else begin
			if (wr_stb && wr_addr == `LPER_OFF_MASK && wr_strb == 4'hf) mask_q <= wr_data;
			if (wr_stb && wr_addr == `LPER_OFF_CTRL && wr_strb == 4'hf) ctrl_q <= wr_data;
			irq <= |(err_word & mask_q & 32'h1b00_0004);
		end
	end

	// Unmapped write addresses answer with a slave error
	always @* begin
		case (wr_addr)
		`LPER_OFF_ERR, `LPER_OFF_MASK, `LPER_OFF_CTRL: wr_err = 1'b0;
		`LPER_OFF_CFGHDR, `LPER_OFF_CFGSTAT, `LPER_OFF_CNT: wr_err = 1'b0;
		default: wr_err = 1'b1;
		endcase
	end

	// Read mux; fixed configuration words are read only
	always @* begin
		rd_err = 1'b0;
		case (rd_addr)
		`LPER_OFF_ERR: rd_data = err_word;
		`LPER_OFF_MASK: rd_data = mask_q;
		`LPER_OFF_CTRL: rd_data = ctrl_q;
		`LPER_OFF_CFGHDR: rd_data = {16'h0000, `LPER_INT_PIN, `LPER_HDR_TYPE};
		`LPER_OFF_CFGSTAT: rd_data = {16'h0000, `LPER_CFG_STATUS};
		`LPER_OFF_CNT: rd_data = {16'h0000, err_cnt_q};
		default: begin
			rd_data = 32'h0000_0000;
			rd_err = 1'b1;
		end
		endcase
	end
endmodule // lper_link_err

/* sim/lper_link_err_monitor.sv */
/*
 Checker for the link parity block: link framing, parity, forwarding, flags.
 Assumes a bind onto lper_link_err, one clock aclk, sync reset aresetn.
*/
`timescale 1ns/100ps
module lper_link_err_chk (
	input wire aclk,
	input wire aresetn,
	input wire s_axi_bvalid,
	input wire tx_valid,
	input wire tx_ready,
	input wire tx_sop,
	input wire [7:0] tx_data,
	input wire link_tx_valid,
	input wire link_tx_sop,
	input wire [7:0] link_tx_data,
	input wire link_tx_par,
	input wire link_rx_valid,
	input wire link_rx_sop,
	input wire link_rx_eop,
	input wire [7:0] link_rx_data,
	input wire link_rx_par,
	input wire rx_valid,
	input wire [7:0] rx_data,
	input wire rx_abort,
	input wire rx_bad,
	input wire irq
);
	reg hdr_ok_q;
	reg dbad_q;
	// Odd parity per byte, so an even count of ones is a fault
	wire rx_par_bad = ~^{link_rx_data, link_rx_par};
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	// Packet history, because data parity is only judged at the last byte
	always @(posedge aclk) begin
		if (!aresetn) begin
			hdr_ok_q <= 1'b0;
			dbad_q <= 1'b0;
		end else if (link_rx_valid && link_rx_sop) begin
			hdr_ok_q <= !rx_par_bad;
			dbad_q <= 1'b0;
		end else if (link_rx_valid) begin
			dbad_q <= dbad_q | rx_par_bad;
		end
	end
	sequence s_hdr_bad;
		link_rx_valid && link_rx_sop && rx_par_bad;
	endsequence
	sequence s_data_bad_end;
		link_rx_valid && link_rx_eop && !link_rx_sop && hdr_ok_q && (dbad_q || rx_par_bad);
	endsequence
	a_hdr_abort: assert property (s_hdr_bad |=> rx_abort && !rx_valid)
		else $error("header fault not aborted");
	a_drop_rest: assert property (s_hdr_bad ##1 (link_rx_valid && !link_rx_sop) |=> !rx_valid)
		else $error("aborted packet forwarded");
	a_data_bad: assert property (s_data_bad_end |=> rx_bad)
		else $error("data fault missed");
	a_bad_at_end: assert property (rx_bad |-> $past(link_rx_eop) && $past(link_rx_valid))
		else $error("data fault flagged before packet end");
	a_rx_forward: assert property (rx_valid |-> $past(link_rx_valid) && rx_data == $past(link_rx_data))
		else $error("received byte not forwarded");
	a_tx_parity: assert property (link_tx_valid |-> ^{link_tx_data, link_tx_par})
		else $error("sent byte without odd parity");
	a_tx_forward: assert property (tx_valid && tx_ready |=>
		link_tx_valid && link_tx_data == $past(tx_data) && link_tx_sop == $past(tx_sop))
		else $error("sent byte lost");
	a_irq_holds: assert property ($fell(irq) |->
		$past(s_axi_bvalid) || $past(s_axi_bvalid, 2) || $past(s_axi_bvalid, 3))
		else $error("interrupt dropped without a write");
endmodule // lper_link_err_chk
bind lper_link_err lper_link_err_chk lper_link_err_chk_inst (.*);

/* sim/lper_peer_model.sv */
/*
 Behavioural linecard or peer adapter on the far side of the link.
 Assumes the bench calls send and notify right after a clock edge.
*/
`timescale 1ns/100ps
`include "lper_defines.vh"
module lper_peer_model (
	input wire aclk,
	output reg link_rx_valid,
	output reg link_rx_sop,
	output reg link_rx_eop,
	output reg [7:0] link_rx_data,
	output reg link_rx_par,
	output reg link_err_notify,
	input wire link_tx_valid,
	input wire link_tx_sop,
	input wire link_tx_eop,
	input wire [7:0] link_tx_data,
	input wire link_tx_par
);
	integer n_tx = 0;
	integer n_err_pkt = 0;
	integer n_par_bad = 0;
	initial begin
		{link_rx_valid, link_rx_sop, link_rx_eop, link_rx_par, link_err_notify} = 5'h0;
		link_rx_data = 8'h5a;
	end
	// Check traffic from the adapter; its error packet is a lone marker byte
	always @(posedge aclk) begin
		if (link_tx_valid) begin
			n_tx = n_tx + 1;
			if (!(^{link_tx_data, link_tx_par}))
				n_par_bad = n_par_bad + 1;
			if (link_tx_sop && link_tx_eop && link_tx_data == `LPER_ERRPKT_BYTE)
				n_err_pkt = n_err_pkt + 1;
		end
	end
	// Header carries source id; optional fault in header or second byte
	task send(input [5:0] src, input [7:0] d0, input integer n, input hb, input db);
		integer i;
		reg [7:0] b;
		begin
			for (i = 0; i < n; i = i + 1) begin
				b = (i == 0) ? {2'h2, src} : d0 + i[7:0];
				link_rx_valid <= 1'b1;
				link_rx_sop <= (i == 0);
				link_rx_eop <= (i == n - 1);
				link_rx_data <= b;
				link_rx_par <= ~^b ^ ((i == 0) ? hb : (i == 1) && db);
				@(posedge aclk);
			end
			// Released line shows the inverse, not the last byte
			{link_rx_valid, link_rx_sop, link_rx_eop} <= 3'h0;
			link_rx_data <= ~b;
		end
	endtask
	// Linecard-detected fault reported back as a one-cycle signal
	task notify;
		begin
			link_err_notify <= 1'b1;
			@(posedge aclk);
			link_err_notify <= 1'b0;
		end
	endtask
endmodule // lper_peer_model

/* sim/lper_link_err_tb.sv */
/*
 Self-checking bench for lper_link_err with a behavioural link peer.
 Assumes the checker is bound in and a 25 MHz clock.
*/
`timescale 1ns/100ps
`include "lper_defines.vh"
module lper_link_err_tb;
	reg aclk = 0, aresetn = 0, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
	reg s_axi_arvalid = 0, s_axi_rready = 0, tx_valid = 0, tx_sop = 0, tx_eop = 0, tx_bcast = 0;
	reg [7:0] s_axi_awaddr = 0, s_axi_araddr = 0, tx_data = 0;
	reg [31:0] s_axi_wdata = 0;
	reg [3:0] s_axi_wstrb = 4'hf;
	wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, tx_ready, irq;
	wire [1:0] s_axi_bresp, s_axi_rresp;
	wire [31:0] s_axi_rdata;
	wire link_tx_valid, link_tx_sop, link_tx_eop, link_tx_par, link_rx_valid, link_rx_sop;
	wire link_rx_eop, link_rx_par, link_err_notify, rx_valid, rx_sop, rx_eop, rx_abort, rx_bad;
	wire [7:0] link_tx_data, link_rx_data, rx_data;
	integer n_fail = 0, compares = 0, seed = 32'h80ac, n_bad = 0, n_abort = 0;
	reg [31:0] exp_q[$], msk_q[$], e, m;
	reg [9:0] rx_q[$];
	reg [5:0] s;
	lper_link_err lper_link_err_inst (.*);
	lper_peer_model lper_peer_model_inst (.*);
	initial forever #20 aclk = ~aclk;
	task cmp(input [31:0] got, input [31:0] exp);
		begin
			compares = compares + 1;
			if (got !== exp) begin
				n_fail = n_fail + 1;
				$display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
			end
		end
	endtask
	task close_out;
		begin
			$display("n_fail=%0d compares=%0d", n_fail, compares);
			if (n_fail == 0 && compares > 0)
				$display("DONE - PASS");
			else
				$display("DONE - FAIL");
			$finish;
		end
	endtask
	task to;
		begin
			n_fail = n_fail + 1;
			close_out;
		end
	endtask
	// Result watcher: oldest expectation against each answer
	always @(posedge aclk) begin
		if (s_axi_rvalid && s_axi_rready) begin
			e = exp_q.pop_front();
			m = msk_q.pop_front();
			cmp(s_axi_rdata & m, e);
		end
		if (rx_valid)
			cmp({rx_eop, rx_sop, rx_data}, rx_q.pop_front());
		n_bad = n_bad + rx_bad;
		n_abort = n_abort + rx_abort;
	end
	task axw(input [7:0] a, input [31:0] d, input [1:0] r);
		integer k;
		begin
			s_axi_awaddr <= a;
			s_axi_wdata <= d;
			{s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
			k = 0;
			do begin
				@(posedge aclk);
				if (s_axi_awready) s_axi_awvalid <= 1'b0;
				if (s_axi_wready) s_axi_wvalid <= 1'b0;
				k = k + 1;
			end while (s_axi_bvalid !== 1'b1 && k < 50);
			if (k >= 50) to;
			cmp(s_axi_bresp, r);
		end
	endtask
	task axr(input [7:0] a, input [31:0] x, input [31:0] mk, input [1:0] r);
		integer k;
		begin
			exp_q.push_back(x);
			msk_q.push_back(mk);
			s_axi_araddr <= a;
			{s_axi_arvalid, s_axi_rready} <= 2'h3;
			k = 0;
			do begin
				@(posedge aclk);
				if (s_axi_arready) s_axi_arvalid <= 1'b0;
				k = k + 1;
			end while (s_axi_rvalid !== 1'b1 && k < 50);
			if (k >= 50) to;
			cmp(s_axi_rresp, r);
		end
	endtask
	task pkt(input integer n, input hb, input db);
		reg [7:0] d0;
		integer i;
		begin
			d0 = $random(seed);
			if (!hb) for (i = 0; i < n; i = i + 1)
				rx_q.push_back({i == n - 1, i == 0, i == 0 ? {2'h2, s} : d0 + i[7:0]});
			lper_peer_model_inst.send(s, d0, n, hb, db);
			repeat (4) @(posedge aclk);
		end
	endtask
	task txs(input integer n);
		integer i, k;
		begin
			for (i = 0; i < n; i = i + 1) begin
				{tx_valid, tx_bcast, tx_sop, tx_eop} <= {2'h3, i == 0, i == n - 1};
				tx_data <= $random(seed);
				k = 0;
				do begin
					@(posedge aclk);
					k = k + 1;
				end while (tx_ready !== 1'b1 && k < 50);
				if (k >= 50) to;
			end
			tx_valid <= 1'b0;
			repeat (3) @(posedge aclk);
		end
	endtask
	// Main sequence
	initial begin
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		s = $random(seed);
		axr(`LPER_OFF_CFGHDR, 32'h100, ~32'h0, 2'h0);
		axr(`LPER_OFF_CFGSTAT, 32'h400, ~32'h0, 2'h0);
		axr(8'h40, 32'h0, ~32'h0, 2'h2);
		axw(8'h40, 32'h1, 2'h2);
		axr(`LPER_OFF_MASK, 32'h0, ~32'h0, 2'h0);
		pkt(4, 1'b0, 1'b0);
		pkt(5, 1'b0, 1'b1);
		cmp(n_bad, 32'h1);
		cmp(irq, 32'h0);
		axr(`LPER_OFF_ERR, 32'h0300_0001 | {16'h0, s, 10'h0}, ~32'h0, 2'h0);
		axw(`LPER_OFF_MASK, 32'h1b00_0004, 2'h0);
		repeat (2) @(posedge aclk);
		cmp(irq, 32'h1);
		axr(`LPER_OFF_ERR, 32'h0300_0001 | {16'h0, s, 10'h0}, ~32'h0, 2'h0);
		axw(`LPER_OFF_ERR, 32'h0300_0000, 2'h0);
		repeat (2) @(posedge aclk);
		cmp(irq, 32'h0);
		pkt(3, 1'b1, 1'b0);
		cmp(n_abort, 32'h1);
		cmp(irq, 32'h1);
		axr(`LPER_OFF_ERR, 32'h4, 32'h7, 2'h0);
		axw(`LPER_OFF_ERR, ~32'h0, 2'h0);
		lper_peer_model_inst.notify;
		repeat (3) @(posedge aclk);
		cmp(irq, 32'h1);
		axr(`LPER_OFF_ERR, 32'h1800_0000, 32'h1800_0000, 2'h0);
		axw(`LPER_OFF_ERR, ~32'h0, 2'h0);
		axw(`LPER_OFF_CTRL, 32'h1, 2'h0);
		pkt(3, 1'b0, 1'b1);
		cmp(lper_peer_model_inst.n_err_pkt, 32'h1);
		axw(`LPER_OFF_CTRL, 32'h0, 2'h0);
		axw(`LPER_OFF_ERR, ~32'h0, 2'h0);
		txs(6);
		cmp(lper_peer_model_inst.n_tx, 32'h7);
		cmp(lper_peer_model_inst.n_par_bad, 32'h0);
		pkt(6, 1'b0, 1'b1);
		cmp(n_bad, 32'h3);
		axr(`LPER_OFF_ERR, 32'h0300_0001 | {16'h0, s, 10'h0}, ~32'h0, 2'h0);
		close_out;
	end
endmodule // lper_link_err_tb
